// [logic/memory_type_range_lookup.sv]
// Memory-type range lookup: eleven fixed-range registers and eight
// variable base/mask pairs, reached over a 64-bit register port.
// Assumes requests come from logic on sys_clk; global enables and the
// default type are driven by the surrounding core on the same clock.
//
// Notes on behaviour
// R1: First 1 MB split into 88 fixed ranges.
// R2: 00000h-7FFFFh: eight 64 KB ranges, one register.
// R3: 80000h-BFFFFh: sixteen 16 KB ranges, two registers.
// R4: C0000h-FFFFFh: sixty-four 4 KB ranges, eight registers.
// R5: Byte fields ascend with address, low byte first.
// R6: Registers start 00000h, 80000h, A0000h, C0000h..F8000h.
// R7: Eight variable pairs, each base plus mask.
// R8: Base bits 7-0 hold the standard type.
// R9: Base bits 51-12 hold upper address bits.
// R10: Base 4 KB aligned; fewer bits may exist.
// R11: Mask bit 11 enables the pair.
// R12: Mask bits 51-12 hold the range mask.
// R13: Software writes zero to reserved bits.
// R14: All defined pair fields read and write.
// R15: Hit when masked base equals masked target.
// R16: Standard type codes 00h, 01h, 04h-06h.
// R17: Global enable clear makes everything uncacheable.
// R18: Unmatched addresses take the default type.
// R19: Below 1 MB, fixed field beats variable ranges.
module memory_type_range_lookup #(
    parameter int PHYS_ADDR_W = memory_type_pkg::PHYS_ADDR_BITS,
    parameter int PAIRS       = memory_type_pkg::VAR_PAIR_COUNT
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regIndex,
    input  wire logic [63:0] regWrData,
    output logic      [63:0] regRdData,
    output logic             regAck,
    output logic             regFault,
    input  wire logic        rangesOn,
    input  wire logic        fixedRangesOn,
    input  wire logic [7:0]  defaultType,
    input  wire logic        lookupReq,
    input  wire logic [51:0] lookupAddr,
    output logic             memTypeValid,
    output logic      [7:0]  memType,
    output logic             lookupFixedHit,
    output logic             lookupVarHit
);

    localparam int UW = PHYS_ADDR_W - memory_type_pkg::PAGE_SHIFT;
    localparam int FL = memory_type_pkg::FIELD_LSB;

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    memory_type_pkg::fixed_bank_t fixedType;                // R1
    logic [7:0]       rangeType  [PAIRS];
    logic [UW-1:0]    rangeBase  [PAIRS];
    logic [UW-1:0]    rangeMask  [PAIRS];
    logic [PAIRS-1:0] rangeValid;

    ////////////////////////////////////////////////////////////////////////
    // Index decode

    logic       isFixed;
    logic       isVar;
    logic       isMaskReg;
    logic [3:0] fixedSel;
    logic [2:0] pairSel;
    logic [7:0] varOffset;

    always_comb begin
        varOffset = regIndex - memory_type_pkg::IDX_VAR_FIRST;
        fixedSel  = regIndex[3:0];
        pairSel   = varOffset[3:1];
        isMaskReg = varOffset[0];
        isFixed   = 1'b0;
        isVar     = 1'b0;
        if (regIndex <= memory_type_pkg::IDX_FIXED_4K_F8000) begin
            isFixed = 1'b1;                                 // R6
        end else if (regIndex >= memory_type_pkg::IDX_VAR_FIRST &&
                     regIndex <= memory_type_pkg::IDX_VAR_LAST &&
                     32'(pairSel) < PAIRS) begin
            isVar = 1'b1;                                   // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fixed-range registers, all 64 bits read/write

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fixedType <= '0;
        end else if (regWrite && isFixed) begin
            fixedType[fixedSel] <= regWrData;               // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Variable pairs; reserved bits are not stored and read as zero

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PAIRS; i++) begin
                rangeType[i] <= memory_type_pkg::TYPE_RESET;
                rangeBase[i] <= '0;
            end
        end else if (regWrite && isVar && !isMaskReg) begin
            // R8
            rangeType[pairSel] <= regWrData[memory_type_pkg::TYPE_MSB:
                                            memory_type_pkg::TYPE_LSB];
            rangeBase[pairSel] <= regWrData[FL +: UW];      // R9 R10 R13
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PAIRS; i++) begin
                rangeMask[i] <= '0;
            end
            rangeValid <= '0;
        end else if (regWrite && isVar && isMaskReg) begin
            rangeMask[pairSel]  <= regWrData[FL +: UW];     // R12 R13
            rangeValid[pairSel] <=
                regWrData[memory_type_pkg::VALID_BIT];      // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path and access answer

    logic [63:0] next_regRdData;

    always_comb begin
        next_regRdData = 64'h0000_0000_0000_0000;
        if (isFixed) begin
            next_regRdData = fixedType[fixedSel];
        end else if (isVar && !isMaskReg) begin
            next_regRdData[7:0]      = rangeType[pairSel];  // R14
            next_regRdData[FL +: UW] = rangeBase[pairSel];
        end else if (isVar) begin
            next_regRdData[FL +: UW] = rangeMask[pairSel];  // R14
            next_regRdData[memory_type_pkg::VALID_BIT] =
                rangeValid[pairSel];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 64'h0000_0000_0000_0000;
        end else if (regRead) begin
            regRdData <= next_regRdData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regAck   <= 1'b0;
            regFault <= 1'b0;
        end else begin
            regAck   <= regRead || regWrite;
            regFault <= (regRead || regWrite) && !isFixed && !isVar;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lookup: fixed field, variable comparators, resolution

    logic [7:0]       fixedField;
    logic [PAIRS-1:0] varHit;
    logic [UW-1:0]    targetPage;
    logic             belowOneMeg;

    assign targetPage  = lookupAddr[FL +: UW];
    assign belowOneMeg =
        (lookupAddr[51:memory_type_pkg::FIXED_SPAN_BITS] == 32'h0);

    fixed_field_select u_fixed (                            // R2 R3 R4
        .fixedType (fixedType),
        .lowAddr   (lookupAddr[19:0]),
        .fieldType (fixedField)
    );

    for (genvar g = 0; g < PAIRS; g++) begin : g_pair
        variable_range_match #(
            .UW (UW)
        ) u_match (
            .rangeBaseField (rangeBase[g]),
            .rangeMaskField (rangeMask[g]),
            .pairValid      (rangeValid[g]),                // R11
            .targetPage     (targetPage),
            .hit            (varHit[g])                     // R15
        );
    end

    logic [7:0] varType;
    logic       varAnyUc;
    logic [7:0] next_memType;
    logic       next_fixedHit;
    logic       next_varHit;

    // Overlapping pairs: uncached wins, else the lowest-numbered pair
    always_comb begin
        varType  = defaultType;
        varAnyUc = 1'b0;
        for (int i = PAIRS - 1; i >= 0; i--) begin
            if (varHit[i]) begin
                varType = rangeType[i];
                if (rangeType[i] == memory_type_pkg::UNCACHED_TYPE) begin
                    varAnyUc = 1'b1;
                end
            end
        end
        if (varAnyUc) begin
            varType = memory_type_pkg::UNCACHED_TYPE;       // R16
        end
    end

    always_comb begin
        next_fixedHit = 1'b0;
        next_varHit   = 1'b0;
        if (!rangesOn) begin
            next_memType = memory_type_pkg::UNCACHED_TYPE;  // R17
        end else if (fixedRangesOn && belowOneMeg) begin
            next_memType  = fixedField;                     // R19
            next_fixedHit = 1'b1;
        end else if (|varHit) begin
            next_memType = varType;
            next_varHit  = 1'b1;
        end else begin
            next_memType = defaultType;                     // R18
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            memTypeValid <= 1'b0;
        end else begin
            memTypeValid <= lookupReq;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            memType        <= memory_type_pkg::UNCACHED_TYPE;
            lookupFixedHit <= 1'b0;
            lookupVarHit   <= 1'b0;
        end else if (lookupReq) begin
            memType        <= next_memType;
            lookupFixedHit <= next_fixedHit;
            lookupVarHit   <= next_varHit;
        end
    end

endmodule

// [logic/memory_type_pkg.sv]
// Shared constants for the memory-type range lookup block.
// Assumes one core clock; register indices are block-local numbers.
package memory_type_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Address space
    localparam int PHYS_ADDR_BITS  = 52;
    localparam int PAGE_SHIFT      = 12;
    localparam int FIXED_SPAN_BITS = 20;
    localparam int FIXED_REG_COUNT = 11;
    localparam int VAR_PAIR_COUNT  = 8;

    // Fixed-range layout: granule select bits within the first 1 MB
    localparam int SEL_HALF_BIT    = 19;
    localparam int SEL_QUARTER_BIT = 18;
    localparam int BYTE_64K_LSB    = 16;
    localparam int BYTE_16K_LSB    = 14;
    localparam int BYTE_4K_LSB     = 12;
    localparam int REG_16K_BIT     = 17;
    localparam int REG_4K_LSB      = 15;
    localparam logic [3:0] FIX_REG_64K   = 4'h0;
    localparam logic [3:0] FIX_REG_16K   = 4'h1;
    localparam logic [3:0] FIX_REG_4K    = 4'h3;
    localparam int         TYPE_FIELD_W  = 8;

    typedef logic [FIXED_REG_COUNT-1:0][63:0] fixed_bank_t;

    ////////////////////////////////////////////////////////////////////////
    // Register indices on the model-specific register port
    localparam logic [7:0] IDX_FIXED_64K_00000 = 8'h00;
    localparam logic [7:0] IDX_FIXED_16K_80000 = 8'h01;
    localparam logic [7:0] IDX_FIXED_16K_A0000 = 8'h02;
    localparam logic [7:0] IDX_FIXED_4K_C0000  = 8'h03;
    localparam logic [7:0] IDX_FIXED_4K_F8000  = 8'h0A;
    localparam logic [7:0] IDX_VAR_FIRST       = 8'h10;
    localparam logic [7:0] IDX_VAR_LAST        = 8'h1F;

    // Variable pair field positions
    localparam int TYPE_LSB   = 0;
    localparam int TYPE_MSB   = 7;
    localparam int VALID_BIT  = 11;
    localparam int FIELD_LSB  = 12;

    // Reset values
    localparam logic [63:0] FIXED_RESET = 64'h0000_0000_0000_0000;
    localparam logic [7:0]  TYPE_RESET  = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Standard memory type encodings
    localparam logic [7:0] UNCACHED_TYPE        = 8'h00;
    localparam logic [7:0] WRITE_COMBINING_TYPE = 8'h01;
    localparam logic [7:0] WRITE_THROUGH_TYPE   = 8'h04;
    localparam logic [7:0] WRITE_PROTECT_TYPE   = 8'h05;
    localparam logic [7:0] WRITE_BACK_TYPE      = 8'h06;

endpackage

// [logic/variable_range_match.sv]
// One variable range comparator: base and mask against a page number.
// Assumes mask and base are already held at the implemented width.
module variable_range_match #(
    parameter int UW = 40
) (
    input  wire logic [UW-1:0] rangeBaseField,
    input  wire logic [UW-1:0] rangeMaskField,
    input  wire logic          pairValid,
    input  wire logic [UW-1:0] targetPage,
    output logic               hit
);

    // Masked base equals masked target page
    assign hit = pairValid &&
        ((rangeBaseField & rangeMaskField) ==
         (targetPage & rangeMaskField));

endmodule

// [logic/fixed_field_select.sv]
// Picks the byte-wide type field that covers an address below 1 MB.
// Assumes the caller has already checked that the address is below 1 MB.
module fixed_field_select (
    input  wire memory_type_pkg::fixed_bank_t fixedType,
    input  wire logic [19:0]                  lowAddr,
    output logic [7:0]                        fieldType
);

    logic [3:0]  regSel;
    logic [2:0]  byteSel;
    logic [63:0] word;

    always_comb begin
        if (!lowAddr[memory_type_pkg::SEL_HALF_BIT]) begin
            // 64 KB granules, one register
            regSel  = memory_type_pkg::FIX_REG_64K;
            byteSel = lowAddr[memory_type_pkg::BYTE_64K_LSB +: 3];
        end else if (!lowAddr[memory_type_pkg::SEL_QUARTER_BIT]) begin
            // 16 KB granules, two registers
            regSel  = memory_type_pkg::FIX_REG_16K +
                      {3'h0, lowAddr[memory_type_pkg::REG_16K_BIT]};
            byteSel = lowAddr[memory_type_pkg::BYTE_16K_LSB +: 3];
        end else begin
            // 4 KB granules, eight registers
            regSel  = memory_type_pkg::FIX_REG_4K +
                      {1'h0, lowAddr[memory_type_pkg::REG_4K_LSB +: 3]};
            byteSel = lowAddr[memory_type_pkg::BYTE_4K_LSB +: 3];
        end
        word      = fixedType[regSel];
        fieldType = word[{byteSel, 3'h0} +: 8];
    end

endmodule

// [verif/memory_type_range_lookup_chk.sv]
// Checker for the memory-type range lookup block, bound to its top.
// Assumes one clock domain, sys_clk, with rst_n active low.
module memory_type_range_lookup_chk (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regIndex,
    input wire logic [63:0] regRdData,
    input wire logic        regAck,
    input wire logic        regFault,
    input wire logic        rangesOn,
    input wire logic        fixedRangesOn,
    input wire logic [7:0]  defaultType,
    input wire logic        lookupReq,
    input wire logic [51:0] lookupAddr,
    input wire logic        memTypeValid,
    input wire logic [7:0]  memType,
    input wire logic        lookupFixedHit,
    input wire logic        lookupVarHit
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_lookup_taken;
        lookupReq ##1 memTypeValid;
    endsequence

    a_ack_after_req: assert property ((regWrite || regRead) |=> regAck)
        else $error("register ack missing");
    a_no_stray_ack: assert property (!(regWrite || regRead) |=> !regAck)
        else $error("register ack without request");
    a_fault_needs_ack: assert property (regFault |-> regAck)
        else $error("fault without ack");
    a_fault_reads_zero: assert property ($past(regRead) && regFault |->
        regRdData == 64'h0) else $error("unmapped read not zero");
    a_lookup_answers: assert property (lookupReq |-> s_lookup_taken)
        else $error("lookup result missing");
    a_no_stray_valid: assert property (!lookupReq |=> !memTypeValid)
        else $error("lookup valid without request");
    a_off_uncached: assert property (lookupReq && !rangesOn |=>
        memType == 8'h00 && !lookupFixedHit && !lookupVarHit)
        else $error("disabled ranges not uncached");
    a_fixed_wins: assert property (
        lookupReq && rangesOn && fixedRangesOn && lookupAddr[51:20] == 32'h0
        |=> lookupFixedHit && !lookupVarHit)
        else $error("fixed field not used below 1 MB");
    a_default_miss: assert property (
        memTypeValid && $past(rangesOn) && !lookupFixedHit && !lookupVarHit
        |-> memType == $past(defaultType))
        else $error("miss did not take default type");
    a_type_holds: assert property (!lookupReq |=> $stable(memType))
        else $error("memory type changed without lookup");
endmodule
////////////////////////////////////////////////////////////////////////////
bind memory_type_range_lookup memory_type_range_lookup_chk i_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regIndex(regIndex), .regRdData(regRdData),
    .regAck(regAck), .regFault(regFault), .rangesOn(rangesOn),
    .fixedRangesOn(fixedRangesOn), .defaultType(defaultType),
    .lookupReq(lookupReq), .lookupAddr(lookupAddr),
    .memTypeValid(memTypeValid), .memType(memType),
    .lookupFixedHit(lookupFixedHit), .lookupVarHit(lookupVarHit));

// [verif/memory_type_range_lookup_tb.sv]
// Self-checking bench for the memory-type range lookup block.
// Assumes the checker file is compiled alongside for its bind.
module memory_type_range_lookup_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regIndex = 8'h00;
    logic [63:0] regWrData = 64'h0;
    logic [63:0] regRdData;
    logic        regAck, regFault, memTypeValid, lookupFixedHit, lookupVarHit;
    logic        rangesOn = 1'b1;
    logic        fixedRangesOn = 1'b1;
    logic [7:0]  defaultType = 8'h05;
    logic        lookupReq = 1'b0;
    logic [51:0] lookupAddr = 52'h0;
    logic [7:0]  memType;
    int          err_count = 0;
    int          checked = 0;
    logic [63:0] rd;
    logic        flt;

    memory_type_range_lookup i_memory_type_range_lookup (.sys_clk(sys_clk),
        .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
        .regIndex(regIndex), .regWrData(regWrData), .regRdData(regRdData),
        .regAck(regAck), .regFault(regFault), .rangesOn(rangesOn),
        .fixedRangesOn(fixedRangesOn), .defaultType(defaultType),
        .lookupReq(lookupReq), .lookupAddr(lookupAddr),
        .memTypeValid(memTypeValid), .memType(memType),
        .lookupFixedHit(lookupFixedHit), .lookupVarHit(lookupVarHit));

    always #25 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic access(input logic wr, input logic [7:0] idx,
                          input logic [63:0] d);
        @(posedge sys_clk);
        #1;
        regWrite = wr;
        regRead = !wr;
        regIndex = idx;
        regWrData = d;
        @(posedge sys_clk);
        #1;
        regWrite = 1'b0;
        regRead = 1'b0;
        check("ack", {63'h0, regAck}, 64'h1);
        rd = regRdData;
        flt = regFault;
    endtask

    task automatic lookup(input logic [51:0] a, input logic [7:0] t,
                          input logic [1:0] hits);
        @(posedge sys_clk);
        #1;
        lookupReq = 1'b1;
        lookupAddr = a;
        @(posedge sys_clk);
        #1;
        lookupReq = 1'b0;
        check("valid", {63'h0, memTypeValid}, 64'h1);
        check("type", {56'h0, memType}, {56'h0, t});
        check("hits", {62'h0, lookupFixedHit, lookupVarHit}, {62'h0, hits});
    endtask

    // Start or last byte address of fixed granule b of register r
    function automatic logic [51:0] fixed_addr(int r, int b, int e);
        if (r == 0) return 52'(b * 32'h10000 + e * 32'hFFFF);
        if (r < 3) return 52'(32'h80000 + (r - 1) * 32'h20000
                              + b * 32'h4000 + e * 32'h3FFF);
        return 52'(32'hC0000 + (r - 3) * 32'h8000 + b * 32'h1000
                   + e * 32'hFFF);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic test_fixed;
        logic [63:0] v;
        access(1'b0, 8'h11, 64'h0);
        check("mask reset", rd, 64'h0);
        for (int r = 0; r < 11; r++) begin
            for (int b = 0; b < 8; b++) v[b*8+:8] = 8'(r * 8 + b + 1);
            access(1'b1, 8'(r), v);
            access(1'b0, 8'(r), 64'h0);
            check("fixed reg", rd, v);
            check("fixed fault", {63'h0, flt}, 64'h0);
        end
        for (int r = 0; r < 11; r++)
            for (int b = 0; b < 8; b++)
                for (int e = 0; e < 2; e++)
                    lookup(fixed_addr(r, b, e), 8'(r * 8 + b + 1),
                           2'b10);
    endtask

    task automatic test_pairs;
        logic [7:0] enc [5];
        logic [39:0] pg;
        enc = '{memory_type_pkg::UNCACHED_TYPE,
                memory_type_pkg::WRITE_COMBINING_TYPE,
                memory_type_pkg::WRITE_THROUGH_TYPE,
                memory_type_pkg::WRITE_PROTECT_TYPE,
                memory_type_pkg::WRITE_BACK_TYPE};
        for (int n = 0; n < 8; n++) begin
            pg = 40'(n + 1) << 8;
            access(1'b1, 8'(16 + 2 * n), {12'hFFF, pg, 4'hF, enc[n % 5]});
            access(1'b0, 8'(16 + 2 * n), 64'h0);
            check("base", rd, {12'h0, pg, 4'h0, enc[n % 5]});
            access(1'b1, 8'(17 + 2 * n), {12'hFFF, 40'hFF_FFFF_FF00, 12'hFFF});
            access(1'b0, 8'(17 + 2 * n), 64'h0);
            check("mask", rd,
                  {12'h0, 40'hFF_FFFF_FF00, 12'h800});
            lookup({pg, 12'hFFF} | 52'hFF000, enc[n % 5], 2'b01);
        end
        lookup(52'h90_0000, 8'h05, 2'b00);
        access(1'b1, 8'h1F, {12'h0, 40'hFF_FFFF_FF00, 12'h000});
        lookup(52'h81_1234, 8'h05, 2'b00);
    endtask

    task automatic test_priority;
        access(1'b1, 8'h1C, {12'h0, 40'h0, 4'h0, 8'h06});
        access(1'b1, 8'h1D, {12'h0, 40'hFF_FFFF_FF00, 12'h800});
        lookup(52'h5000, 8'h01, 2'b10);
        fixedRangesOn = 1'b0;
        lookup(52'h5000, 8'h06, 2'b01);
        rangesOn = 1'b0;
        lookup(52'h5000, 8'h00, 2'b00);
        lookup(52'h2F_FFFF, 8'h00, 2'b00);
        rangesOn = 1'b1;
        fixedRangesOn = 1'b1;
    endtask

    task automatic test_unmapped;
        logic [7:0] bad [3];
        bad = '{8'h0B, 8'h20, 8'hFF};
        foreach (bad[i]) begin
            access(1'b1, bad[i], 64'hFFFF_FFFF_FFFF_FFFF);
            check("wr fault", {63'h0, flt}, 64'h1);
            access(1'b0, bad[i], 64'h0);
            check("rd fault", {63'h0, flt}, 64'h1);
            check("rd zero", rd, 64'h0);
        end
    endtask

    task automatic report_and_stop;
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        test_fixed();
        test_pairs();
        test_priority();
        test_unmapped();
        report_and_stop();
    end

    initial begin
        #2ms;
        err_count++;
        report_and_stop();
    end
endmodule
